// ### verilog/irc_pkg.sv
package irc_pkg;

   // Register map, byte addresses on the Avalon-MM slave.
   localparam int IRC_ADDR_W = 4;
   localparam logic [IRC_ADDR_W-1:0] IRC_OFS_MODE = 4'h0;
   localparam logic [IRC_ADDR_W-1:0] IRC_OFS_STATUS = 4'h4;

   // Mode register layout.
   localparam int IRC_MODE_W = 16;
   localparam logic [IRC_MODE_W-1:0] IRC_MODE_RESET = 16'h0000;
   localparam int IRC_BIT_SELECT = 7;
   localparam int IRC_DIV_HI = 6;
   localparam int IRC_DIV_LO = 3;
   localparam int IRC_BIT_PSEL = 2;
   localparam logic [IRC_MODE_W-1:0] IRC_MODE_WMASK = 16'h00FC;

   // Status register layout.
   localparam int IRC_ST_CLK = 0;
   localparam int IRC_ST_TXPULSE = 1;
   localparam int IRC_ST_RXZERO = 2;
   localparam int IRC_ST_MODE = 3;

   // Bit timing counted in 16x oversampling ticks and in timing clock half periods.
   localparam logic [3:0] IRC_TICKS_LAST = 4'hF;
   localparam logic [3:0] IRC_PULSE_TICKS = 4'h3;
   localparam logic [4:0] IRC_RX_BIT_TICKS = 5'h10;
   localparam logic [1:0] IRC_PULSE_HALVES = 2'h3;

   typedef logic [IRC_MODE_W-1:0] irc_mode_t;

endpackage

// ### verilog/irc_codec.sv
// The register addresses and the Avalon-MM slave port were chosen for this implementation.
`timescale 1ns/100ps
module irc_codec
(
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic [irc_pkg::IRC_ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic serialTxData,
   input wire logic serialTick16,
   output logic serialRxData,
   output logic opticalTxOut,
   input wire logic opticalRxIn
);
   import irc_pkg::*;

   irc_mode_t modeReg;
   irc_mode_t next_modeReg;
   logic busAck;
   logic next_busAck;
   logic [31:0] next_avs_readdata;

   logic infraredSelect;
   logic [3:0] pulseClockDivider;
   logic widthSelect;

   logic [3:0] divCnt;
   logic [3:0] next_divCnt;
   logic pulseTimingClock;
   logic next_pulseTimingClock;
   logic timingEdge;

   logic txPrev;
   logic txEdge;
   logic [3:0] txPhase;
   logic [3:0] next_txPhase;
   logic [1:0] halfCnt;
   logic [1:0] next_halfCnt;
   logic txPulse;
   logic next_opticalTxOut;

   logic rxMeta;
   logic rxSync;
   logic rxPrev;
   logic rxRise;
   logic [4:0] rxCnt;
   logic [4:0] next_rxCnt;
   logic rxBitZero;
   logic next_serialRxData;

   function automatic logic [31:0] readWord(input logic [IRC_ADDR_W-1:0] addr, input irc_mode_t mode,
                                            input logic [3:0] st);
      logic [31:0] word;
      word = 32'h0000_0000;
      if (addr == IRC_OFS_MODE)
      begin
         word[IRC_MODE_W-1:0] = mode & IRC_MODE_WMASK;
      end
      else if (addr == IRC_OFS_STATUS)
      begin
         word[3:0] = st;
      end
      return word;
   endfunction

   assign infraredSelect = modeReg[IRC_BIT_SELECT];
   assign pulseClockDivider = modeReg[IRC_DIV_HI:IRC_DIV_LO];
   assign widthSelect = modeReg[IRC_BIT_PSEL];

   // One wait cycle on every access: the answer stands in the cycle after the request is seen.
   assign avs_waitrequest = (avs_read | avs_write) & ~busAck;

   always_comb
   begin
      logic [3:0] st;
      st = 4'h0;
      st[IRC_ST_CLK] = pulseTimingClock;
      st[IRC_ST_TXPULSE] = txPulse;
      st[IRC_ST_RXZERO] = rxBitZero;
      st[IRC_ST_MODE] = infraredSelect;
      next_busAck = (avs_read | avs_write) & ~busAck;
      next_avs_readdata = avs_read ? readWord(avs_address, modeReg, st) : 32'h0000_0000;
      next_modeReg = modeReg;
      if (avs_write && busAck && avs_address == IRC_OFS_MODE && avs_byteenable[0])
      begin
         next_modeReg = {8'h00, avs_writedata[7:0]} & IRC_MODE_WMASK;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         modeReg <= IRC_MODE_RESET;
         busAck <= 1'b0;
         avs_readdata <= 32'h0000_0000;
      end
      else
      begin
         modeReg <= next_modeReg;
         busAck <= next_busAck;
         avs_readdata <= next_avs_readdata;
      end
   end

   // Timing clock: toggles every N+1 core cycles, a period of 2N+2.
   always_comb
   begin
      timingEdge = (divCnt == pulseClockDivider);
      next_divCnt = timingEdge ? 4'h0 : divCnt + 4'h1;
      next_pulseTimingClock = timingEdge ? ~pulseTimingClock : pulseTimingClock;
   end

   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         divCnt <= 4'h0;
         pulseTimingClock <= 1'b0;
      end
      else
      begin
         divCnt <= next_divCnt;
         pulseTimingClock <= next_pulseTimingClock;
      end
   end

   // Transmit: bit phase follows the serial port's own oversampling tick.
   always_comb
   begin
      txEdge = serialTxData != txPrev;
      next_txPhase = txEdge ? 4'h0 : (serialTick16 ? txPhase + 4'h1 : txPhase);
      if (txEdge || (serialTick16 && txPhase == IRC_TICKS_LAST))
      begin
         next_halfCnt = 2'h0;
      end
      else if (timingEdge && halfCnt != IRC_PULSE_HALVES)
      begin
         next_halfCnt = halfCnt + 2'h1;
      end
      else
      begin
         next_halfCnt = halfCnt;
      end
      if (widthSelect)
      begin
         txPulse = ~serialTxData & (txEdge | halfCnt < IRC_PULSE_HALVES);
      end
      else
      begin
         txPulse = ~serialTxData & (txEdge | txPhase < IRC_PULSE_TICKS);
      end
      next_opticalTxOut = infraredSelect ? txPulse : serialTxData;
   end

   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         txPrev <= 1'b1;
         txPhase <= 4'h0;
         halfCnt <= 2'h3;
         opticalTxOut <= 1'b0;
      end
      else
      begin
         txPrev <= serialTxData;
         txPhase <= next_txPhase;
         halfCnt <= next_halfCnt;
         opticalTxOut <= next_opticalTxOut;
      end
   end

   // Receive: a pulse holds the decoded line low for one bit time of sixteen ticks.
   always_comb
   begin
      rxRise = rxSync & ~rxPrev;
      if (rxRise)
      begin
         next_rxCnt = IRC_RX_BIT_TICKS;
      end
      else if (serialTick16 && rxCnt != 5'h00)
      begin
         next_rxCnt = rxCnt - 5'h01;
      end
      else
      begin
         next_rxCnt = rxCnt;
      end
      rxBitZero = rxRise | (rxCnt != 5'h00);
      next_serialRxData = infraredSelect ? ~rxBitZero : rxSync;
   end

   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         rxMeta <= 1'b0;
         rxSync <= 1'b0;
         rxPrev <= 1'b0;
         rxCnt <= 5'h00;
         serialRxData <= 1'b1;
      end
      else
      begin
         rxMeta <= opticalRxIn;
         rxSync <= rxMeta;
         rxPrev <= rxSync;
         rxCnt <= next_rxCnt;
         serialRxData <= next_serialRxData;
      end
   end

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (sys_rst);

   logic [4:0] hiCnt;
   always_ff @(posedge core_clk)
   begin
      if (sys_rst || timingEdge)
      begin
         hiCnt <= 5'h00;
      end
      else
      begin
         hiCnt <= hiCnt + 5'h01;
      end
   end

   // A divider lowered below the running count wraps once; hiCnt then passes fifteen.
   a_divider_period: assert property (timingEdge |-> hiCnt == {1'b0, pulseClockDivider} || hiCnt[4])
      else $error("Timing clock half period differs from divider plus one.");

   a_reserved_zero: assert property (avs_readdata[31:8] == 24'h000000 && (avs_readdata[1:0] == 2'h0
      || !$past(avs_address == IRC_OFS_MODE)))
      else $error("Reserved mode bits read as nonzero.");

   a_mode_reset: assert property ($past(sys_rst) |-> modeReg == 16'h0000)
      else $error("Mode register not zero after reset.");

   a_passthru_tx: assert property (!$past(infraredSelect) && !$past(sys_rst)
      |-> opticalTxOut == $past(serialTxData))
      else $error("Transmit line not passed through in serial mode.");

   a_passthru_rx: assert property (!$past(infraredSelect) && !$past(sys_rst)
      |-> serialRxData == $past(rxSync))
      else $error("Receive line not passed through in serial mode.");

   a_one_idle: assert property ($past(infraredSelect) && $past(serialTxData) |-> !opticalTxOut)
      else $error("Pulse emitted for a serial one bit.");

   sequence zeroStart;
      infraredSelect && !widthSelect && $fell(serialTxData);
   endsequence

   a_zero_pulse: assert property (zeroStart |=> opticalTxOut)
      else $error("No pulse at the start of a serial zero bit.");

   a_pulse_ends: assert property (infraredSelect && !widthSelect && !serialTxData && serialTick16
      && txPhase == 4'h2 && !txEdge |=> ##1 !opticalTxOut)
      else $error("Pulse outlasts three oversampling ticks.");

   sequence rxPulseSeen;
      infraredSelect && rxRise;
   endsequence

   a_rx_decode: assert property (rxPulseSeen ##1 infraredSelect |-> !serialRxData)
      else $error("Received pulse not decoded as zero.");

   a_rx_idle_one: assert property (infraredSelect && !rxBitZero |=> serialRxData || !$past(infraredSelect))
      else $error("Bit without pulse not decoded as one.");

   a_bus_answer: assert property ($rose(avs_read) && avs_waitrequest |=> !avs_waitrequest)
      else $error("Bus access not answered in one wait cycle.");

endmodule // irc_codec

// ### verification/irc_optical_model.sv
`timescale 1ns/100ps
// Optical transceiver: emits light pulses on command and measures emitted ones.
module irc_optical_model
#(parameter int PULSE_CYCLES = 12)
(
   input wire logic core_clk,
   input wire logic fire,
   input wire logic rxLevel,
   input wire logic opticalTxOut,
   output logic opticalRxIn,
   output int txWidth,
   output int txPulses
);
   int run = 0;
   int left = 0;
   initial txPulses = 0;
   initial txWidth = 0;
   // A pulse lasts 3/16 of a 64-cycle bit; rxLevel sets the idle level.
   assign opticalRxIn = rxLevel | (left != 0);
   always @(posedge core_clk)
   begin
      left <= fire ? PULSE_CYCLES : (left != 0 ? left - 1 : 0);
      run <= (opticalTxOut === 1'b1) ? run + 1 : 0;
      if (opticalTxOut === 1'b0 && run != 0)
      begin
         txWidth <= run;
         txPulses <= txPulses + 1;
      end
   end
endmodule // irc_optical_model

// ### verification/tb_infrared_pulse_codec.sv
`timescale 1ns/100ps
module tb_infrared_pulse_codec;
   import irc_pkg::*;
   typedef struct {logic [31:0] wr; logic [31:0] rd; int lo; int hi;} irc_row_s;
   logic core_clk, sys_rst, avs_read, avs_write, serialTxData, serialTick16, fire, rxLevel;
   logic [IRC_ADDR_W-1:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, q;
   logic [3:0] avs_byteenable;
   logic [1:0] tickCnt;
   logic avs_waitrequest, serialRxData, opticalTxOut, opticalRxIn;
   int txWidth, txPulses, p0, failures, compares;
   irc_row_s rows [3] = '{'{32'h0000_0080, 32'h0080, 8, 13},
      '{32'hFFFF_FFBF, 32'h00BC, 17, 25}, '{32'h0000_0084, 32'h0084, 2, 5}};
   irc_codec u_dut (.core_clk(core_clk), .sys_rst(sys_rst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .serialTxData(serialTxData), .serialTick16(serialTick16), .serialRxData(serialRxData),
      .opticalTxOut(opticalTxOut), .opticalRxIn(opticalRxIn));
   irc_optical_model u_opt (.core_clk(core_clk), .fire(fire), .rxLevel(rxLevel),
      .opticalTxOut(opticalTxOut), .opticalRxIn(opticalRxIn), .txWidth(txWidth), .txPulses(txPulses));
   initial
   begin
      core_clk = 0;
      forever #2 core_clk = ~core_clk;
   end
   // Sixteen ticks every 64 cycles, as the serial port gives at 16x oversampling.
   always @(posedge core_clk)
   begin
      tickCnt <= tickCnt + 2'h1;
      serialTick16 <= (tickCnt == 2'h3);
   end
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp)
      begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      @(posedge core_clk);
      avs_read <= !w;
      avs_write <= w;
      avs_address <= a;
      avs_writedata <= d;
      do
      begin
         @(posedge core_clk);
      end
      while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task automatic results();
      $display("Comparisons %0d, failures %0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   initial
   begin
      repeat (20000) @(posedge core_clk);
      failures++;
      results();
   end
   initial
   begin
      failures = 0;
      compares = 0;
      sys_rst = 1'b1;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_address = '0;
      avs_writedata = '0;
      avs_byteenable = 4'hF;
      serialTxData = 1'b1;
      serialTick16 = 1'b0;
      tickCnt = 2'h0;
      fire = 1'b0;
      rxLevel = 1'b1;
      repeat (3) @(posedge core_clk);
      sys_rst <= 1'b0;
      bus(0, IRC_OFS_MODE, 0);
      chk("mode reset", 32'h0, q);
      rxLevel <= 1'b0;
      foreach (rows[i])
      begin
         bus(1, IRC_OFS_MODE, rows[i].wr);
         bus(0, IRC_OFS_MODE, 0);
         chk("mode readback", rows[i].rd, q);
         p0 = txPulses;
         // Bit edges of the serial port fall on its oversampling ticks.
         @(posedge core_clk iff tickCnt == 2'h3);
         serialTxData <= 1'b0;
         repeat (128) @(posedge core_clk);
         serialTxData <= 1'b1;
         repeat (64) @(posedge core_clk);
         chk("pulse count", p0 + 2, txPulses);
         chk("pulse width ok", 1, txWidth >= rows[i].lo && txWidth <= rows[i].hi);
         fire <= 1'b1;
         @(posedge core_clk);
         fire <= 1'b0;
         repeat (8) @(posedge core_clk);
         chk("rx pulse bit", 0, serialRxData);
         repeat (90) @(posedge core_clk);
         chk("rx idle bit", 1, serialRxData);
      end
      bus(0, IRC_OFS_STATUS, 0);
      chk("status select", 1, q[IRC_ST_MODE]);
      bus(0, 4'h8, 0);
      chk("unmapped read", 0, q);
      avs_byteenable <= 4'hE;
      bus(1, IRC_OFS_MODE, 0);
      avs_byteenable <= 4'hF;
      bus(0, IRC_OFS_MODE, 0);
      chk("mode kept", 32'h0084, q);
      bus(1, IRC_OFS_MODE, 0);
      rxLevel <= 1'b1;
      serialTxData <= 1'b0;
      repeat (3) @(posedge core_clk);
      chk("pass low", 0, opticalTxOut);
      repeat (60) @(posedge core_clk);
      chk("pass hold", 0, opticalTxOut);
      serialTxData <= 1'b1;
      rxLevel <= 1'b0;
      repeat (5) @(posedge core_clk);
      chk("pass high", 1, opticalTxOut);
      chk("pass rx", 0, serialRxData);
      rxLevel <= 1'b1;
      bus(1, IRC_OFS_MODE, 32'h0080);
      sys_rst <= 1'b1;
      repeat (3) @(posedge core_clk);
      sys_rst <= 1'b0;
      bus(0, IRC_OFS_MODE, 0);
      chk("mode after reset", 32'h0, q);
      results();
   end
endmodule // tb_infrared_pulse_codec
